// ### inc/vic_pkg.sv
package vic_pkg;

   // Source ranks, 0 is the highest ranking for equal priority
   localparam int NUM_SRC   = 13;
   localparam int NUM_FLAG  = 14;
   localparam int NUM_LVL   = 4;
   localparam int SRC_EXT0  = 0;
   localparam int SRC_BO    = 1;
   localparam int SRC_WD    = 2;
   localparam int SRC_T0    = 3;
   localparam int SRC_TW    = 4;
   localparam int SRC_CONV  = 5;
   localparam int SRC_EXT1  = 6;
   localparam int SRC_KB    = 7;
   localparam int SRC_C1    = 8;
   localparam int SRC_T1    = 9;
   localparam int SRC_C2    = 10;
   localparam int SRC_SER   = 11;
   localparam int SRC_BRK   = 12;
   // Transmit-done shares the serial source with receive-done
   localparam int FLG_TX    = 13;

   // Timing in clocks and machine cycles
   localparam int MC_CLKS   = 4;
   localparam int CALL_MCS  = 4;
   localparam int CALL_CLKS = MC_CLKS * CALL_MCS;
   localparam logic [1:0] POLL_PHASE = 2'h2;

   // Reset values
   localparam logic [NUM_FLAG-1:0] FLAGS_RST = 14'h0000;
   localparam logic [NUM_LVL-1:0]  INSV_RST  = 4'h0;
   localparam logic [15:0]         VEC_RST   = 16'h0000;

   localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{
      16'h0003, 16'h002B, 16'h0053, 16'h000B, 16'h0033, 16'h005B, 16'h0013,
      16'h003B, 16'h0063, 16'h001B, 16'h0043, 16'h0023, 16'h0073};

   typedef logic [3:0] vic_src_t;
   typedef logic [1:0] vic_lvl_t;

endpackage : vic_pkg

// ### inc/vic_arb_if.sv
`timescale 1ns/1ps
interface vic_arb_if;
   import vic_pkg::*;
   logic [NUM_SRC-1:0] req;
   logic [NUM_SRC-1:0] prio_hi;
   logic [NUM_SRC-1:0] prio_lo;
   logic [NUM_LVL-1:0] in_service;
   logic               win_valid;
   vic_src_t           win_src;
   vic_lvl_t           win_lvl;

   modport ctl (output req, prio_hi, prio_lo, in_service,
                input  win_valid, win_src, win_lvl);
   modport arb (input  req, prio_hi, prio_lo, in_service,
                output win_valid, win_src, win_lvl);
endinterface : vic_arb_if

// ### hdl/vic_sync.sv
`timescale 1ns/1ps
module vic_sync #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Data
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } vic_sync_st_t;

   vic_sync_st_t st;
   vic_sync_st_t next_st;

   always_comb begin
      next_st.meta   = din;
      next_st.stable = st.meta;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign dout = st.stable;

endmodule : vic_sync

// ### hdl/vic_arb.sv
`timescale 1ns/1ps
module vic_arb
   import vic_pkg::*;
(
   // Arbitration request and answer
   vic_arb_if.arb bus
);
   // Highest level first, then lowest index (fixed ranking) within a level
   always_comb begin
      int top_busy;
      logic [1:0] lvl;
      top_busy      = -1;
      lvl           = 2'h0;
      bus.win_valid = 1'b0;
      bus.win_src   = 4'h0;
      bus.win_lvl   = 2'h0;
      for (int l = 0; l < NUM_LVL; l++) begin
         if (bus.in_service[l]) begin
            top_busy = l;
         end
      end
      for (int l = NUM_LVL - 1; l >= 0; l--) begin
         for (int i = 0; i < NUM_SRC; i++) begin
            lvl = {bus.prio_hi[i], bus.prio_lo[i]};
            if (!bus.win_valid && bus.req[i] && int'(lvl) == l && l > top_busy) begin
               bus.win_valid = 1'b1;
               bus.win_src   = 4'(i);
               bus.win_lvl   = lvl;
            end
         end
      end
   end

endmodule : vic_arb

// ### hdl/vic_top.sv
`timescale 1ns/1ps
module vic_top
   import vic_pkg::*;
(
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                rst_n,
   // Asynchronous pins
   input  wire logic                ext_irq_pin0,
   input  wire logic                ext_irq_pin1,
   input  wire logic                comp1_out,
   input  wire logic                comp2_out,
   input  wire logic                brake_pin,
   // Peripheral event pulses
   input  wire logic                timer0_ovf,
   input  wire logic                timer1_ovf,
   input  wire logic                wdog_timeout,
   input  wire logic                uart_rx_done,
   input  wire logic                uart_tx_done,
   input  wire logic                conv_done,
   input  wire logic                twowire_status_new,
   input  wire logic                brownout_event,
   input  wire logic                kbd_event,
   // Configuration
   input  wire logic                ext0_trigger_select,
   input  wire logic                ext1_trigger_select,
   input  wire logic [NUM_SRC-1:0]  irq_enable,
   input  wire logic                global_irq_enable,
   input  wire logic [NUM_SRC-1:0]  prio_high_bits,
   input  wire logic [NUM_SRC-1:0]  prio_low_bits,
   // Software flag write
   input  wire logic                flag_wr,
   input  wire logic [NUM_FLAG-1:0] flag_wdata,
   // Core handshake
   input  wire logic                cpu_last_cycle,
   input  wire logic                cpu_block_instr,
   input  wire logic                reti_done,
   // Results
   output logic                     vec_call,
   output logic [15:0]              vec_addr,
   output logic [NUM_LVL-1:0]       in_service,
   output logic                     call_busy,
   output logic [NUM_FLAG-1:0]      flag_status
);
   typedef struct packed {
      logic [1:0]          phase;
      logic                mc_tick;
      logic [1:0]          ext_smp;
      logic [2:0]          pin_prev;
      logic [1:0]          warm;
      logic [NUM_FLAG-1:0] flags;
      logic [NUM_SRC-1:0]  snap;
      logic [NUM_LVL-1:0]  in_service;
      logic                busy;
      logic [4:0]          call_cnt;
      logic                vec_call;
      logic [15:0]         vec_addr;
   } vic_st_t;

   vic_st_t    st;
   vic_st_t    next_st;
   logic [4:0] pins;
   logic       issue;
   logic [NUM_FLAG-1:0] hw_set;
   logic [NUM_FLAG-1:0] hw_clr;

   vic_arb_if arb_bus ();

   vic_sync #(.WIDTH(5)) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .din   ({brake_pin, comp2_out, comp1_out, ext_irq_pin1, ext_irq_pin0}),
      .dout  (pins)
   );

   vic_arb u_arb (
      .bus (arb_bus.arb)
   );

   assign arb_bus.req        = st.snap;
   assign arb_bus.prio_hi    = prio_high_bits;
   assign arb_bus.prio_lo    = prio_low_bits;
   assign arb_bus.in_service = st.in_service;

   // Poll at a fixed phase of the machine cycle, outside any call
   assign issue = st.phase == POLL_PHASE && !st.busy && arb_bus.win_valid
                  && cpu_last_cycle && !cpu_block_instr;

   always_comb begin
      logic [1:0] trig;
      trig   = {ext1_trigger_select, ext0_trigger_select};
      hw_set = '0;
      hw_clr = '0;
      if (st.mc_tick) begin
         hw_set[SRC_EXT0] = trig[0] && st.ext_smp[0] && !pins[0];
         hw_set[SRC_EXT1] = trig[1] && st.ext_smp[1] && !pins[1];
      end
      hw_set[SRC_T0]   = timer0_ovf;
      hw_set[SRC_T1]   = timer1_ovf;
      hw_set[SRC_WD]   = wdog_timeout;
      hw_set[SRC_SER]  = uart_rx_done;
      hw_set[FLG_TX]   = uart_tx_done;
      hw_set[SRC_CONV] = conv_done;
      // Pin history is junk until the synchroniser has filled
      if (st.warm == 2'h3) begin
         hw_set[SRC_C1]  = pins[2] != st.pin_prev[0];
         hw_set[SRC_C2]  = pins[3] != st.pin_prev[1];
         hw_set[SRC_BRK] = pins[4] && !st.pin_prev[2];
      end
      hw_set[SRC_TW]   = twowire_status_new;
      hw_set[SRC_BO]   = brownout_event;
      hw_set[SRC_KB]   = kbd_event;
      if (issue) begin
         hw_clr[SRC_T0]   = arb_bus.win_src == 4'(SRC_T0);
         hw_clr[SRC_T1]   = arb_bus.win_src == 4'(SRC_T1);
         hw_clr[SRC_EXT0] = arb_bus.win_src == 4'(SRC_EXT0) && trig[0];
         hw_clr[SRC_EXT1] = arb_bus.win_src == 4'(SRC_EXT1) && trig[1];
      end
   end

   always_comb begin
      logic [1:0]          trig;
      logic [NUM_FLAG-1:0] base;
      logic [NUM_SRC-1:0]  raw;
      trig    = {ext1_trigger_select, ext0_trigger_select};
      base    = '0;
      raw     = '0;
      next_st = st;
      next_st.phase   = st.phase + 2'h1;
      next_st.mc_tick = st.phase == 2'(MC_CLKS - 1);
      next_st.pin_prev = pins[4:2];
      next_st.vec_call = 1'b0;
      if (st.warm != 2'h3) begin
         next_st.warm = st.warm + 2'h1;
      end

      // Software write first, hardware set wins over any clear
      base = flag_wr ? flag_wdata : st.flags;
      next_st.flags = (base & ~hw_clr) | hw_set;
      if (st.mc_tick) begin
         next_st.ext_smp = pins[1:0];
         // Level mode: flag follows the inverted pin, never cleared on vectoring
         if (!trig[0]) begin
            next_st.flags[SRC_EXT0] = !pins[0];
         end
         if (!trig[1]) begin
            next_st.flags[SRC_EXT1] = !pins[1];
         end
         // Fresh snapshot every machine cycle, old requests dropped
         raw = st.flags[NUM_SRC-1:0];
         raw[SRC_SER] = st.flags[SRC_SER] | st.flags[FLG_TX];
         next_st.snap = raw & irq_enable & {NUM_SRC{global_irq_enable}};
      end

      // Completion from RETI drops the highest active level
      if (reti_done) begin
         for (int l = 0; l < NUM_LVL; l++) begin
            if (st.in_service[l] && !(|(st.in_service >> (l + 1)))) begin
               next_st.in_service[l] = 1'b0;
            end
         end
      end

      if (st.busy) begin
         next_st.call_cnt = st.call_cnt - 5'h1;
         if (st.call_cnt == 5'h0) begin
            next_st.busy = 1'b0;
         end
      end

      if (issue) begin
         // Core pushes PC only, then loads this vector
         next_st.vec_call = 1'b1;
         next_st.vec_addr = VEC_TABLE[arb_bus.win_src];
         next_st.in_service[arb_bus.win_lvl] = 1'b1;
         next_st.busy     = 1'b1;
         next_st.call_cnt = 5'(CALL_CLKS - 1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st            <= '0;
         st.flags      <= FLAGS_RST;
         st.in_service <= INSV_RST;
         st.vec_addr   <= VEC_RST;
         st.ext_smp    <= 2'h3;
      end else begin
         st <= next_st;
      end
   end

   assign vec_call    = st.vec_call;
   assign vec_addr    = st.vec_addr;
   assign in_service  = st.in_service;
   assign call_busy   = st.busy;
   assign flag_status = st.flags;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_edge_seen;
      st.mc_tick && ext0_trigger_select && st.ext_smp[0] && !pins[0];
   endsequence

   sequence s_call_hold;
      call_busy [*8];
   endsequence

   property p_edge_set;
      s_edge_seen |=> flag_status[SRC_EXT0];
   endproperty
   a_edge_set: assert property (p_edge_set) else $error("edge not latched");

   property p_level_follow;
      st.mc_tick && !ext0_trigger_select && !flag_wr |=> flag_status[SRC_EXT0] == !$past(pins[0]);
   endproperty
   a_level_follow: assert property (p_level_follow) else $error("level flag wrong");

   property p_timer_clear;
      issue && arb_bus.win_src == 4'(SRC_T0) && !timer0_ovf |=> !flag_status[SRC_T0];
   endproperty
   a_timer_clear: assert property (p_timer_clear) else $error("timer flag kept");

   property p_wd_sticky;
      flag_status[SRC_WD] && !flag_wr |=> flag_status[SRC_WD];
   endproperty
   a_wd_sticky: assert property (p_wd_sticky) else $error("watchdog flag lost");

   property p_global_block;
      st.mc_tick && !global_irq_enable |=> st.snap == '0;
   endproperty
   a_global_block: assert property (p_global_block) else $error("request passed gate");

   property p_boundary;
      vec_call |-> $past(cpu_last_cycle) && !$past(cpu_block_instr);
   endproperty
   a_boundary: assert property (p_boundary) else $error("call off boundary");

   property p_call_len;
      vec_call |-> s_call_hold ##1 s_call_hold ##1 !call_busy;
   endproperty
   a_call_len: assert property (p_call_len) else $error("call length wrong");

   property p_top_level;
      in_service[3] |-> !issue;
   endproperty
   a_top_level: assert property (p_top_level) else $error("level 3 preempted");

   property p_service_mark;
      vec_call |-> in_service[$past(arb_bus.win_lvl)];
   endproperty
   a_service_mark: assert property (p_service_mark) else $error("level not marked");

   property p_edge_clear;
      issue && arb_bus.win_src == 4'(SRC_EXT0) && ext0_trigger_select && !hw_set[SRC_EXT0]
         |=> !flag_status[SRC_EXT0];
   endproperty
   a_edge_clear: assert property (p_edge_clear) else $error("edge flag kept");

   property p_serial_sticky;
      flag_status[SRC_SER] && !flag_wr |=> flag_status[SRC_SER];
   endproperty
   a_serial_sticky: assert property (p_serial_sticky) else $error("serial flag lost");

   property p_conv_sticky;
      flag_status[SRC_CONV] && !flag_wr |=> flag_status[SRC_CONV];
   endproperty
   a_conv_sticky: assert property (p_conv_sticky) else $error("conversion flag lost");

   property p_brake_set;
      st.warm == 2'h3 && pins[4] && !st.pin_prev[2] |=> flag_status[SRC_BRK];
   endproperty
   a_brake_set: assert property (p_brake_set) else $error("brake not latched");

   property p_reti_drop;
      reti_done && in_service[3] && !issue |=> !in_service[3];
   endproperty
   a_reti_drop: assert property (p_reti_drop) else $error("service level kept");

endmodule : vic_top

// ### tb/vic_core_model.sv
`timescale 1ns/1ps
module vic_core_model (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // Controller side
   input  wire logic        vec_call,
   input  wire logic [15:0] vec_addr,
   output logic             reti_done,
   // Bench side
   input  wire logic        ret_req,
   input  wire logic        ret_is_reti,
   output logic [15:0]      pc
);
   logic [15:0] stack [8];
   logic [2:0]  depth;
   logic        pend;

   // Call pushes only the PC, status word untouched
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc    <= 16'h0100;
         depth <= 3'h0;
         pend  <= 1'b0;
      end else begin
         pend <= ret_req & ret_is_reti;
         if (vec_call) begin
            stack[depth] <= pc;
            depth        <= depth + 3'h1;
            pc           <= vec_addr;
         end else if (ret_req && depth != 3'h0) begin
            pc    <= stack[depth - 3'h1];
            depth <= depth - 3'h1;
         end
      end
   end

   // Strobe launched off the falling edge
   always @(negedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reti_done <= 1'b0;
      end else begin
         reti_done <= pend;
      end
   end
endmodule : vic_core_model

// ### tb/tb_vic_top.sv
`timescale 1ns/1ps
module tb_vic_top;
   logic        clk, rst_n, p0, p1, c1, c2, brk, ts0, ts1, ge, fwr, last, blk, rq, rti;
   logic        vcall, busy, rdone;
   logic [8:0]  ev;
   logic [12:0] en, ph, pl;
   logic [13:0] fwd, flg;
   logic [13:0] hwc = 14'h0249;
   logic [15:0] vaddr, pc;
   logic [3:0]  insv;
   int          miscompares, cmp_count, n, s;
   int          evb [9] = '{3, 9, 2, 11, 13, 5, 4, 1, 7};
   logic [15:0] vt [13] = '{16'h0003, 16'h002B, 16'h0053, 16'h000B, 16'h0033, 16'h005B,
      16'h0013, 16'h003B, 16'h0063, 16'h001B, 16'h0043, 16'h0023, 16'h0073};

   vic_top dut (.clk(clk), .rst_n(rst_n), .ext_irq_pin0(p0), .ext_irq_pin1(p1),
      .comp1_out(c1), .comp2_out(c2), .brake_pin(brk), .timer0_ovf(ev[0]),
      .timer1_ovf(ev[1]), .wdog_timeout(ev[2]), .uart_rx_done(ev[3]), .uart_tx_done(ev[4]),
      .conv_done(ev[5]), .twowire_status_new(ev[6]), .brownout_event(ev[7]),
      .kbd_event(ev[8]), .ext0_trigger_select(ts0), .ext1_trigger_select(ts1),
      .irq_enable(en), .global_irq_enable(ge), .prio_high_bits(ph), .prio_low_bits(pl),
      .flag_wr(fwr), .flag_wdata(fwd), .cpu_last_cycle(last), .cpu_block_instr(blk),
      .reti_done(rdone), .vec_call(vcall), .vec_addr(vaddr), .in_service(insv),
      .call_busy(busy), .flag_status(flg));
   vic_core_model core (.clk(clk), .rst_n(rst_n), .vec_call(vcall), .vec_addr(vaddr),
      .reti_done(rdone), .ret_req(rq), .ret_is_reti(rti), .pc(pc));

   always #2 clk = ~clk;

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic tick(input int k);
      repeat (k) @(negedge clk);
   endtask : tick

   task automatic setf(input logic [13:0] v);
      fwd = v;
      fwr = 1'b1;
      tick(1);
      fwr = 1'b0;
      tick(1);
   endtask : setf

   // Bounded wait for a vectored call
   task automatic waitc(input logic exp);
      logic got;
      got = 1'b0;
      repeat (60) begin
         @(negedge clk);
         if (vcall === 1'b1) begin
            got = 1'b1;
            break;
         end
      end
      check("call", {15'h0000, got}, {15'h0000, exp});
   endtask : waitc

   task automatic do_ret(input logic k);
      rq = 1'b1;
      rti = k;
      tick(1);
      rq = 1'b0;
      tick(1);
   endtask : do_ret

   task automatic summarize();
      $display("Compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : summarize

   initial begin
      repeat (30000) @(posedge clk);
      miscompares++;
      summarize();
   end

   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {p0, p1, c1, c2, ts0, ts1, ge, last} = 8'hFF;
      {brk, fwr, blk, rq, rti} = 5'h00;
      {ev, en, ph, pl, fwd} = '0;
      tick(8);
      rst_n = 1'b1;
      check("insv", insv, 4'h0);
      check("flags", flg, 14'h0000);
      for (int i = 0; i < 9; i++) begin
         ev = 9'h001 << i;
         tick(1);
         ev = 9'h000;
         tick(2);
         check("evflag", flg, 14'h0001 << evb[i]);
         setf(14'h0000);
      end
      {c1, c2, brk} = 3'h1;
      tick(12);
      check("pinflag", flg, 14'h1500);
      setf(14'h0000);
      for (int b = 0; b < 14; b++) begin
         s = (b == 13) ? 11 : b;
         en = 13'h0001 << s;
         setf(14'h0001 << b);
         waitc(1'b1);
         check("vec", vaddr, vt[s]);
         check("flag", flg[b], !hwc[b]);
         n = 0;
         while (busy === 1'b1 && n < 40) begin
            n++;
            tick(1);
         end
         check("busy", n[15:0], 16'h0010);
         check("pc", pc, vt[s]);
         en = 13'h0000;
         setf(14'h0000);
         do_ret(1'b1);
         check("pcret", pc, 16'h0100);
         check("insv", insv, 4'h0);
      end
      setf(14'h0004);
      waitc(1'b0);
      en = 13'h0004;
      ge = 1'b0;
      waitc(1'b0);
      {ge, last} = 2'h2;
      waitc(1'b0);
      {last, blk} = 2'h3;
      waitc(1'b0);
      blk = 1'b0;
      waitc(1'b1);
      check("wdflag", flg[2], 1'b1);
      waitc(1'b0);
      setf(14'h0000);
      ph = 13'h0230;
      pl = 13'h0030;
      en = 13'h0200;
      setf(14'h0200);
      waitc(1'b1);
      check("insv", insv, 4'h5);
      en = 13'h0010;
      setf(14'h0010);
      waitc(1'b1);
      check("insv", insv, 4'hD);
      en = 13'h0020;
      setf(14'h0020);
      waitc(1'b0);
      setf(14'h0000);
      do_ret(1'b0);
      check("insv", insv, 4'hD);
      do_ret(1'b1);
      check("insv", insv, 4'h5);
      do_ret(1'b1);
      do_ret(1'b1);
      check("insv", insv, 4'h0);
      en = 13'h0008;
      last = 1'b0;
      setf(14'h0008);
      tick(12);
      setf(14'h0000);
      tick(4);
      last = 1'b1;
      waitc(1'b0);
      {ph, pl} = '0;
      en = 13'h1FFF;
      setf(14'h0210);
      waitc(1'b1);
      check("tie", vaddr, 16'h0033);
      setf(14'h0000);
      do_ret(1'b1);
      pl = 13'h0200;
      setf(14'h0210);
      waitc(1'b1);
      check("prio", vaddr, 16'h001B);
      setf(14'h0000);
      do_ret(1'b1);
      en = 13'h0001;
      p0 = 1'b0;
      waitc(1'b1);
      check("edge", flg[0], 1'b0);
      p0 = 1'b1;
      tick(8);
      do_ret(1'b1);
      {ts0, p0} = 2'h0;
      waitc(1'b1);
      check("level", flg[0], 1'b1);
      do_ret(1'b1);
      waitc(1'b1);
      p0 = 1'b1;
      en = 13'h0000;
      do_ret(1'b1);
      {ts1, p1} = 2'h0;
      en = 13'h0040;
      waitc(1'b1);
      check("vec1", vaddr, vt[6]);
      check("level1", flg[6], 1'b1);
      p1 = 1'b1;
      en = 13'h0000;
      do_ret(1'b1);
      check("insv", insv, 4'h0);
      summarize();
   end
endmodule : tb_vic_top
